/* rtl/awt_ctrl.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - multi-channel sequence goes idle after the rollover channel, channel back to analog input zero
// - writing trigger source control aborts running sequence, starts nothing
// - bit 7 picks analog channel or dedicated trigger input as source
// - kind zero: channel field selects analog input 0 to 15
// - kind one: codes 0 to 3 select dedicated inputs, others reserved
// - without dedicated inputs, kind bit only stored; analog channel stays source
// - writing rollover channel control aborts running sequence, starts nothing
// - trigger acts only when enabled; analog source gets digital buffer enabled only while trigger enabled
module awt_ctrl import awt_pkg::*; #(
    parameter bit HAS_DEDICATED = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [15:0] i_analog_trig,
    input wire logic [3:0] i_ded_trig,
    output logic o_busy,
    output logic [3:0] o_chan,
    output logic o_conv_start,
    output logic o_abort,
    output logic [15:0] o_dig_buf_en
);
    // ==========================================
    // registers
    logic [3:0] rollover_r;
    logic [7:0] trigsrc_r;
    logic [1:0] seqctl_r;
    logic [7:0] rdata_r;
    logic trig_prev_r;
    logic [3:0] slot_r;
    logic [3:0] chan_r;
    awt_state_t state_r;
    logic trig_now;
    logic legal;
    logic wr_roll;
    logic wr_trig;
    logic ext_start;
    logic sw_start;
    logic abort;
    logic slot_done;

    assign wr_roll = i_wr && (i_addr == AWT_OFS_ROLLOVER);
    assign wr_trig = i_wr && (i_addr == AWT_OFS_TRIGSRC);
    assign abort = wr_roll || wr_trig;
    assign sw_start = i_wr && (i_addr == AWT_OFS_SEQCTL) && i_wdata[AWT_SEQ_START_BIT];
    assign slot_done = (slot_r == AWT_CONV_CYCLES - 4'h1);

    awt_trig_mux #(
        .HAS_DEDICATED(HAS_DEDICATED)
    ) u_mux (
        .i_kind(trigsrc_r[AWT_KIND_BIT]),
        .i_chan(trigsrc_r[3:0]),
        .i_analog_trig(i_analog_trig),
        .i_ded_trig(i_ded_trig),
        .o_trig(trig_now),
        .o_legal(legal)
    );

    // rising edge of the selected source; reserved codes never fire
    assign ext_start = seqctl_r[AWT_SEQ_ETEN_BIT] && legal && trig_now && !trig_prev_r;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rollover_r <= AWT_ROLLOVER_RST;
            trigsrc_r <= AWT_TRIGSRC_RST;
            seqctl_r <= AWT_SEQCTL_RST;
        end else begin
            if (wr_roll) begin
                rollover_r <= i_wdata[3:0];
            end
            if (wr_trig) begin
                trigsrc_r <= i_wdata;
            end
            if (i_wr && (i_addr == AWT_OFS_SEQCTL)) begin
                seqctl_r <= i_wdata[1:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig_now;
        end
    end

    // ==========================================
    // sequencer: abort wins over any start in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= AWT_IDLE;
            slot_r <= 4'h0;
            chan_r <= 4'h0;
        end else begin
            case (state_r)
                AWT_IDLE: begin
                    slot_r <= 4'h0;
                    if (!abort && (sw_start || ext_start)) begin
                        state_r <= AWT_RUN;
                        chan_r <= 4'h0;
                    end
                end
                AWT_RUN: begin
                    if (abort) begin
                        state_r <= AWT_IDLE;
                        slot_r <= 4'h0;
                    end else if (slot_done) begin
                        slot_r <= 4'h0;
                        if (!seqctl_r[AWT_SEQ_MULTI_CHANNEL_MODE_BIT]) begin
                            state_r <= AWT_IDLE;
                        end else if (chan_r == rollover_r) begin
                            // code zero is reserved: channel 0 gets one slot, then the sequence goes idle, harmless
                            chan_r <= 4'h0;
                            state_r <= AWT_IDLE;
                        end else begin
                            chan_r <= chan_r + 4'h1;
                        end
                    end else begin
                        slot_r <= slot_r + 4'h1;
                    end
                end
                default: begin
                    state_r <= AWT_IDLE;
                end
            endcase
        end
    end

    assign o_busy = (state_r == AWT_RUN);
    assign o_chan = chan_r;
    assign o_conv_start = o_busy && (slot_r == 4'h0);
    assign o_abort = abort && o_busy;

    // digital buffer only for an analog source with trigger enabled
    always_comb begin
        o_dig_buf_en = 16'h0000;
        if (seqctl_r[AWT_SEQ_ETEN_BIT] && !(trigsrc_r[AWT_KIND_BIT] && HAS_DEDICATED)) begin
            o_dig_buf_en[trigsrc_r[3:0]] = 1'b1;
        end
    end

    // ==========================================
    // read port, data one cycle after strobe
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                AWT_OFS_ROLLOVER: rdata_r <= {4'h0, rollover_r};
                AWT_OFS_TRIGSRC: rdata_r <= {trigsrc_r[7], 3'h0, trigsrc_r[3:0]};
                AWT_OFS_SEQCTL: rdata_r <= {6'h00, seqctl_r};
                AWT_OFS_STATUS: rdata_r <= {3'h0, o_busy, chan_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign o_rdata = rdata_r;
endmodule
`default_nettype wire

/* rtl/awt_pkg.sv */
package awt_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] AWT_OFS_ROLLOVER = 8'h00;
    localparam logic [7:0] AWT_OFS_TRIGSRC = 8'h01;
    localparam logic [7:0] AWT_OFS_SEQCTL = 8'h02;
    localparam logic [7:0] AWT_OFS_STATUS = 8'h03;
    // ==========================================
    // field positions
    localparam int AWT_KIND_BIT = 7;
    localparam int AWT_SEQ_MULTI_CHANNEL_MODE_BIT = 0;
    localparam int AWT_SEQ_ETEN_BIT = 1;
    localparam int AWT_SEQ_START_BIT = 2;
    localparam int AWT_STAT_BUSY_BIT = 4;
    // ==========================================
    // reset values and highest dedicated code
    localparam logic [3:0] AWT_ROLLOVER_RST = 4'hF;
    localparam logic [7:0] AWT_TRIGSRC_RST = 8'h00;
    localparam logic [1:0] AWT_SEQCTL_RST = 2'h0;
    localparam logic [3:0] AWT_DED_MAX = 4'h3;
    // ==========================================
    // timing: cycles one conversion slot takes
    localparam logic [3:0] AWT_CONV_CYCLES = 4'hA;
    typedef enum logic [0:0] {
        AWT_IDLE = 1'b0,
        AWT_RUN = 1'b1
    } awt_state_t;
endpackage

/* rtl/awt_trig_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module awt_trig_mux import awt_pkg::*; #(
    parameter bit HAS_DEDICATED = 1'b1
) (
    input wire logic i_kind,
    input wire logic [3:0] i_chan,
    input wire logic [15:0] i_analog_trig,
    input wire logic [3:0] i_ded_trig,
    output logic o_trig,
    output logic o_legal
);
    // ==========================================
    // source select
    always_comb begin
        o_legal = 1'b1;
        if (i_kind && HAS_DEDICATED) begin
            o_legal = (i_chan <= AWT_DED_MAX);
            o_trig = o_legal && i_ded_trig[i_chan[1:0]];
        end else begin
            // kind bit ignored without dedicated inputs
            o_trig = i_analog_trig[i_chan];
        end
    end
endmodule
`default_nettype wire

/* verif/awt_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module awt_ctrl_checker import awt_pkg::*; (
    input wire logic i_clk_sys, i_nrst, i_wr, i_rd,
    input wire logic [7:0] i_addr, i_wdata, o_rdata,
    input wire logic [15:0] i_analog_trig, o_dig_buf_en,
    input wire logic [3:0] i_ded_trig, o_chan,
    input wire logic o_busy, o_conv_start, o_abort
);
    // ====
    // sequencer, buffer and read port checks
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence s_ctl_wr; i_wr && i_addr <= AWT_OFS_TRIGSRC && o_busy; endsequence
    sequence s_gap; !o_conv_start [*8]; endsequence
    property p_abort_cause; s_ctl_wr |-> o_abort; endproperty
    property p_abort_only; o_abort |-> s_ctl_wr; endproperty
    property p_abort_stop; o_abort |=> !o_busy; endproperty
    property p_seq_begin; $rose(o_busy) |-> o_chan == 4'h0 && o_conv_start; endproperty
    property p_slot_len; o_conv_start |=> s_gap; endproperty
    property p_chan_step;
        o_busy && $changed(o_chan) && !$rose(o_busy) |-> o_chan == $past(o_chan) + 4'h1;
    endproperty
    property p_buf_onehot; $countones(o_dig_buf_en) <= 1; endproperty
    property p_rd_quiet; !i_rd |=> o_rdata == 8'h00; endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("no abort");
    a_abort_only: assert property (p_abort_only) else $error("stray abort");
    a_abort_stop: assert property (p_abort_stop) else $error("busy kept");
    a_seq_begin: assert property (p_seq_begin) else $error("bad start");
    a_slot_len: assert property (p_slot_len) else $error("short slot");
    a_chan_step: assert property (p_chan_step) else $error("bad step");
    a_buf_onehot: assert property (p_buf_onehot) else $error("buffers");
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data");
endmodule
bind awt_ctrl awt_ctrl_checker u_chk (.*);
`default_nettype wire

/* verif/tb_adc_wrap_and_trigger_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_wrap_and_trigger_select import awt_pkg::*;;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [15:0] i_analog_trig = 16'h0000, o_dig_buf_en, n = 16'h0000, last, n0;
    logic [3:0] i_ded_trig = 4'h0, o_chan;
    logic o_busy, o_conv_start, o_abort;
    logic [7:0] rv [3];
    int miscompares = 0, n_checks = 0, cyc = 0, r;
    awt_ctrl DUT (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_analog_trig(i_analog_trig),
        .i_ded_trig(i_ded_trig),
        .o_busy(o_busy),
        .o_chan(o_chan),
        .o_conv_start(o_conv_start),
        .o_abort(o_abort),
        .o_dig_buf_en(o_dig_buf_en)
    );
    // ====
    // clock, slot counter, hang guard
    initial forever #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (o_conv_start === 1'b1) begin
            n <= n + 16'h0001;
            last <= {12'h000, o_chan};
        end
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end
    // ====
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        // one idle edge so the next call never re-drives the strobe this step
        @(posedge i_clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk({8'h00, o_rdata}, {8'h00, e});
        @(posedge i_clk_sys);
    endtask
    // polls on the falling edge so a busy flag launched this edge is seen
    task automatic wait_idle();
        @(negedge i_clk_sys);
        repeat (400) if (o_busy !== 1'b0) @(negedge i_clk_sys);
        @(posedge i_clk_sys);
    endtask
    function automatic logic [15:0] exp_buf(input logic [7:0] s, input logic et);
        return (et && !s[7]) ? 16'h0001 << s[3:0] : 16'h0000;
    endfunction
    task automatic trig(input logic [7:0] s, input logic [15:0] a, input logic [3:0] d,
            input logic et, input logic e);
        wr(AWT_OFS_SEQCTL, {6'h00, et, 1'b0});
        wr(AWT_OFS_TRIGSRC, s);
        i_analog_trig <= a;
        i_ded_trig <= d;
        repeat (3) @(posedge i_clk_sys);
        chk({15'h0000, o_busy}, {15'h0000, e});
        chk(o_dig_buf_en, exp_buf(s, et));
        wait_idle();
        i_analog_trig <= 16'h0000;
        i_ded_trig <= 4'h0;
        @(posedge i_clk_sys);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ====
    // main sequence
    initial begin
        r = $urandom(22);
        repeat (2) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(posedge i_clk_sys);
        rd(AWT_OFS_ROLLOVER, 8'h0F);
        rd(AWT_OFS_TRIGSRC, 8'h00);
        rd(8'h10, 8'h00);
        r = $urandom;
        wr(AWT_OFS_TRIGSRC, r[7:0]);
        rd(AWT_OFS_TRIGSRC, r[7:0] & 8'h8F);
        $display("test regs done");
        rv = '{8'h01, 8'h0F, 8'h02 + 8'($urandom % 13)};
        foreach (rv[i]) begin
            wr(AWT_OFS_ROLLOVER, rv[i]);
            n0 = n;
            wr(AWT_OFS_SEQCTL, 8'h05);
            wait_idle();
            chk(n - n0, {8'h00, rv[i]} + 16'h0001);
            chk(last, {8'h00, rv[i]});
        end
        for (int a = 0; a < 2; a++) begin
            wr(AWT_OFS_SEQCTL, 8'h05);
            repeat (14) @(posedge i_clk_sys);
            wr(a[7:0], 8'h0F);
            n0 = n;
            repeat (30) @(posedge i_clk_sys);
            chk(n - n0 + {15'h0000, o_busy}, 16'h0000);
        end
        $display("test sequence done");
        for (int k = 0; k < 16; k++) trig(8'(k), 16'h0001 << k, 4'h0, 1'b1, 1'b1);
        for (int k = 0; k < 4; k++) trig(8'h80 | 8'(k), 16'h0000, 4'h1 << k, 1'b1, 1'b1);
        trig(8'h84 + 8'($urandom % 12), 16'hFFFF, 4'hF, 1'b1, 1'b0);
        trig(8'h03, 16'hFFF7, 4'hF, 1'b1, 1'b0);
        trig(8'h03, 16'h0008, 4'h0, 1'b0, 1'b0);
        $display("test trigger done");
        finish_test();
    end
endmodule
`default_nettype wire
